// ---- hw/ebh_pkg.sv ----
// Behaviour
// - write strobe low only while driving data
// - memory captures data on strobe rising edge
// - strobe pulses on program, data, io writes
// - write strobe floats in hold or float
// - master holds takeover request until finished
// - granted takeover floats address, data, control
// - release acknowledge low while lines float
// - float input floats ack, global req, fetch
// - global request low during global accesses
// - ready only when global memory available
// - global region up to 32K words
// - global request floats when float low
// - master waits ack, then drives global req
// - fetch indicator low for instruction addresses
// - fetch indicator floats when float low
// - in hold, fetch indicator grants ram request
// - master drives address pins during dma
// - master direction high read, low write
// - master strobe low selects each access
// - waiting for ready pauses, resamples each cycle
package ebh_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int GLOBAL_WORDS = 32768;
   localparam int CLK_NS = 100;
   localparam int WAIT_CYCLES = 1;
   localparam logic [1:0] SPACE_PROG = 2'h0;
   localparam logic [1:0] SPACE_DATA = 2'h1;
   localparam logic [1:0] SPACE_IO = 2'h2;
   localparam logic [1:0] SPACE_GLOBAL = 2'h3;
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_ACCESS = 5'h02,
      ST_STROBE = 5'h04,
      ST_HOLD = 5'h08,
      ST_DMA = 5'h10
   } ebh_state_t;
endpackage : ebh_pkg

// ---- hw/ebh_bus_if.sv ----
`timescale 1ns/1ps
interface ebh_bus_if;
   import ebh_pkg::*;
   // address pins: device output + enable (low = driving), master output + enable
   logic [ADDR_W-1:0] dev_addr;
   logic dev_addr_oe_n;
   logic [ADDR_W-1:0] mst_addr;
   logic mst_addr_oe_n;
   logic [DATA_W-1:0] dev_data;
   logic dev_data_oe_n;
   logic [DATA_W-1:0] mst_data;
   logic mst_data_oe_n;
   logic dev_rw;
   logic dev_ctl_oe_n;
   logic mst_rw;
   logic dev_access_strobe_n;
   logic mst_access_strobe_n;
   logic mst_ctl_oe_n;
   logic dev_wr_strobe_n;
   logic dev_wr_oe_n;
   logic dev_space_n_data;
   logic dev_space_n_prog;
   logic dev_space_n_io;
   logic takeover_req_n;
   logic bus_released_ack_n;
   logic dev_ack_oe_n;
   logic dev_global_mem_req_n;
   logic dev_gmr_oe_n;
   logic mst_global_mem_req_n;
   logic mst_gmr_oe_n;
   logic fetch_addr_valid_n;
   logic dev_fetch_oe_n;
   logic ready;
   // resolved pin levels (pull-ups where nobody drives)
   wire [ADDR_W-1:0] addr = !dev_addr_oe_n ? dev_addr : (!mst_addr_oe_n ? mst_addr : '1);
   wire [DATA_W-1:0] data = !dev_data_oe_n ? dev_data : (!mst_data_oe_n ? mst_data : '1);
   wire rw = !dev_ctl_oe_n ? dev_rw : (!mst_ctl_oe_n ? mst_rw : 1'b1);
   wire access_strobe_n = !dev_ctl_oe_n ? dev_access_strobe_n
      : (!mst_ctl_oe_n ? mst_access_strobe_n : 1'b1);
   wire wr_strobe_n = !dev_wr_oe_n ? dev_wr_strobe_n : 1'b1;
   wire global_mem_req_n = !dev_gmr_oe_n ? dev_global_mem_req_n
      : (!mst_gmr_oe_n ? mst_global_mem_req_n : 1'b1);
   wire ack_n = !dev_ack_oe_n ? bus_released_ack_n : 1'b1;
   wire fetch_n = !dev_fetch_oe_n ? fetch_addr_valid_n : 1'b1;
   modport device
   (
      output dev_addr, dev_addr_oe_n, dev_data, dev_data_oe_n, dev_rw, dev_ctl_oe_n,
      output dev_access_strobe_n, dev_wr_strobe_n, dev_wr_oe_n,
      output dev_space_n_data, dev_space_n_prog, dev_space_n_io,
      output bus_released_ack_n, dev_ack_oe_n, dev_global_mem_req_n, dev_gmr_oe_n,
      output fetch_addr_valid_n, dev_fetch_oe_n,
      input takeover_req_n, ready, addr, data, rw, access_strobe_n, global_mem_req_n
   );
   modport master
   (
      output mst_addr, mst_addr_oe_n, mst_data, mst_data_oe_n, mst_rw,
      output mst_access_strobe_n, mst_ctl_oe_n, takeover_req_n, ready,
      output mst_global_mem_req_n, mst_gmr_oe_n,
      input data, ack_n, fetch_n, wr_strobe_n, addr, global_mem_req_n
   );
endinterface : ebh_bus_if

// ---- hw/ebh_device.sv ----
`timescale 1ns/1ps
module ebh_device
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   ebh_bus_if.device bus,
   input wire logic i_float_n,
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire logic i_req_write,
   input wire logic i_req_fetch,
   input wire logic [1:0] i_req_space,
   input wire logic [ebh_pkg::ADDR_W-1:0] i_req_addr,
   input wire logic [ebh_pkg::DATA_W-1:0] i_req_wdata,
   output logic o_rsp_valid,
   output logic [ebh_pkg::DATA_W-1:0] o_rsp_rdata,
   output logic o_in_hold,
   output logic o_ram_we,
   output logic [ebh_pkg::ADDR_W-1:0] o_ram_addr,
   output logic [ebh_pkg::DATA_W-1:0] o_ram_wdata,
   input wire logic [ebh_pkg::DATA_W-1:0] i_ram_rdata
);
   import ebh_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] hold_sync_reg;
   logic [1:0] ready_sync_reg;
   logic [1:0] gmr_sync_reg;
   logic [1:0] acc_stb_sync_reg;
   logic acc_stb_prev_reg;
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         hold_sync_reg <= 2'h3;
         ready_sync_reg <= 2'h0;
         gmr_sync_reg <= 2'h3;
         acc_stb_sync_reg <= 2'h3;
         acc_stb_prev_reg <= 1'b1;
      end
      else
      begin
         hold_sync_reg <= {hold_sync_reg[0], bus.takeover_req_n};
         ready_sync_reg <= {ready_sync_reg[0], bus.ready};
         gmr_sync_reg <= {gmr_sync_reg[0], bus.global_mem_req_n};
         acc_stb_sync_reg <= {acc_stb_sync_reg[0], bus.access_strobe_n};
         acc_stb_prev_reg <= acc_stb_sync_reg[1];
      end
   end
   wire hold_req = !hold_sync_reg[1];
   wire ready_s = ready_sync_reg[1];
   wire dma_req = !gmr_sync_reg[1];
   wire acc_stb_fall = acc_stb_prev_reg && !acc_stb_sync_reg[1];
   ////////////////////////////////////////////////////////////////////////////
   // access state machine
   ebh_state_t state_reg, state_next;
   logic write_reg, fetch_reg;
   logic [1:0] space_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg, rdata_reg;
   logic rsp_reg;
   wire idle = state_reg == ST_IDLE;
   wire start = idle && i_req_valid && !hold_req;
   // wait states: each low ready costs one more cycle before resampling
   wire done = (state_reg == ST_STROBE) && ready_s;
   wire in_hold = (state_reg == ST_HOLD) || (state_reg == ST_DMA);
   wire is_global = space_reg == SPACE_GLOBAL;
   assign o_req_ready = start;
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (hold_req)
               state_next = ST_HOLD;
            else if (i_req_valid)
               state_next = ST_ACCESS;
         ST_ACCESS: state_next = ST_STROBE;
         ST_STROBE:
            if (ready_s)
               state_next = ST_IDLE;
         ST_HOLD:
            if (!hold_req)
               state_next = ST_IDLE;
            else if (dma_req)
               state_next = ST_DMA;
         ST_DMA:
            if (!hold_req)
               state_next = ST_IDLE;
            else if (!dma_req)
               state_next = ST_HOLD;
         default: state_next = ST_IDLE;
      endcase
   end
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_reg <= ST_IDLE;
         write_reg <= 1'b0;
         fetch_reg <= 1'b0;
         space_reg <= SPACE_DATA;
         addr_reg <= 16'h0000;
         wdata_reg <= 16'h0000;
         rdata_reg <= 16'h0000;
         rsp_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         rsp_reg <= done;
         if (start)
         begin
            write_reg <= i_req_write;
            fetch_reg <= i_req_fetch && !i_req_write;
            space_reg <= i_req_space;
            // global window is 32K words: top address bit dropped
            addr_reg <= (i_req_space == SPACE_GLOBAL) ?
               {1'b0, i_req_addr[14:0]} : i_req_addr;
            wdata_reg <= i_req_wdata;
         end
         if (done && !write_reg)
            rdata_reg <= bus.data;
      end
   end
   assign o_rsp_valid = rsp_reg;
   assign o_rsp_rdata = rdata_reg;
   assign o_in_hold = in_hold;
   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   wire active = (state_reg == ST_ACCESS) || (state_reg == ST_STROBE);
   wire own_bus = i_float_n && !in_hold;
   assign bus.dev_addr = addr_reg;
   assign bus.dev_addr_oe_n = !own_bus;
   assign bus.dev_ctl_oe_n = !own_bus;
   assign bus.dev_rw = !(active && write_reg);
   assign bus.dev_access_strobe_n = !(state_reg == ST_STROBE);
   assign bus.dev_space_n_data = !(active && space_reg == SPACE_DATA);
   assign bus.dev_space_n_prog = !(active && space_reg == SPACE_PROG);
   assign bus.dev_space_n_io = !(active && space_reg == SPACE_IO);
   assign bus.dev_data = wdata_reg;
   assign bus.dev_data_oe_n = !(own_bus && active && write_reg);
   // strobe low only in the strobe phase, data already out from access phase
   assign bus.dev_wr_strobe_n = !(state_reg == ST_STROBE && write_reg);
   assign bus.dev_wr_oe_n = !own_bus;
   assign bus.bus_released_ack_n = !in_hold;
   assign bus.dev_ack_oe_n = !i_float_n;
   assign bus.dev_global_mem_req_n = !(active && is_global);
   // released in hold so the master can drive it as a dma request
   assign bus.dev_gmr_oe_n = !(i_float_n && !in_hold);
   assign bus.fetch_addr_valid_n = (state_reg == ST_DMA) ? 1'b0
      : !(active && fetch_reg && !in_hold);
   assign bus.dev_fetch_oe_n = !i_float_n;
   ////////////////////////////////////////////////////////////////////////////
   // dma into on-chip ram, one access per strobe fall
   wire dma_stb = (state_reg == ST_DMA) && acc_stb_fall;
   assign o_ram_we = dma_stb && !bus.rw;
   assign o_ram_addr = bus.addr;
   assign o_ram_wdata = bus.data;
   // dma reads: ram read data is not driven onto the pins, i_ram_rdata is unused
   // the device data pins stay floating for the whole time it holds no bus ownership
endmodule : ebh_device

// ---- hw/ebh_master.sv ----
`timescale 1ns/1ps
module ebh_master
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   ebh_bus_if.master bus,
   input wire logic i_ready,
   input wire logic i_dma_valid,
   input wire logic i_dma_write,
   input wire logic [ebh_pkg::ADDR_W-1:0] i_dma_addr,
   input wire logic [ebh_pkg::DATA_W-1:0] i_dma_wdata,
   output logic o_dma_done,
   output logic o_granted,
   output logic [ebh_pkg::DATA_W-1:0] o_wr_capture
);
   import ebh_pkg::*;
   logic [1:0] ack_sync_reg, fetch_sync_reg, wr_sync_reg;
   logic wr_prev_reg;
   logic [DATA_W-1:0] cap_reg;
   logic [DATA_W-1:0] data_d1_reg, data_d2_reg, data_d3_reg;
   logic [2:0] phase_reg;
   logic busy_reg, done_reg, write_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   wire released = !ack_sync_reg[1];
   wire granted = released && !fetch_sync_reg[1];
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         ack_sync_reg <= 2'h3;
         fetch_sync_reg <= 2'h3;
         wr_sync_reg <= 2'h3;
         wr_prev_reg <= 1'b1;
         cap_reg <= 16'h0000;
         data_d1_reg <= 16'h0000;
         data_d2_reg <= 16'h0000;
         data_d3_reg <= 16'h0000;
         phase_reg <= 3'h0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         write_reg <= 1'b0;
         addr_reg <= 16'h0000;
         wdata_reg <= 16'h0000;
      end
      else
      begin
         ack_sync_reg <= {ack_sync_reg[0], bus.ack_n};
         fetch_sync_reg <= {fetch_sync_reg[0], bus.fetch_n};
         wr_sync_reg <= {wr_sync_reg[0], bus.wr_strobe_n};
         wr_prev_reg <= wr_sync_reg[1];
         // data delayed to line up with the synced strobe: device drops data as strobe rises,
         // so the last sample taken while the strobe was low is the one kept
         data_d1_reg <= bus.data;
         data_d2_reg <= data_d1_reg;
         data_d3_reg <= data_d2_reg;
         if (!wr_prev_reg && wr_sync_reg[1])
            cap_reg <= data_d3_reg;
         done_reg <= 1'b0;
         if (!busy_reg && i_dma_valid)
         begin
            busy_reg <= 1'b1;
            write_reg <= i_dma_write;
            addr_reg <= i_dma_addr;
            wdata_reg <= i_dma_wdata;
            phase_reg <= 3'h0;
         end
         else if (busy_reg && granted)
         begin
            phase_reg <= phase_reg + 3'h1;
            if (phase_reg == 3'h7)
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end
   // request held for the whole transfer, dropped only when finished
   assign bus.takeover_req_n = !busy_reg;
   assign bus.ready = i_ready;
   assign bus.mst_gmr_oe_n = !(busy_reg && released);
   assign bus.mst_global_mem_req_n = 1'b0;
   assign bus.mst_addr = addr_reg;
   assign bus.mst_addr_oe_n = !(busy_reg && released);
   assign bus.mst_ctl_oe_n = !(busy_reg && granted);
   assign bus.mst_rw = !write_reg;
   // strobe low mid-window so the device sees a clean falling edge
   assign bus.mst_access_strobe_n = !(phase_reg >= 3'h2 && phase_reg < 3'h5);
   assign bus.mst_data = wdata_reg;
   assign bus.mst_data_oe_n = !(busy_reg && granted && write_reg);
   assign o_dma_done = done_reg;
   assign o_granted = granted;
   assign o_wr_capture = cap_reg;
endmodule : ebh_master

// ---- dv/ebh_assertions.sv ----
`timescale 1ns/1ps
module ebh_assertions
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_float_n,
   input wire logic [ebh_pkg::ADDR_W-1:0] dev_addr,
   input wire logic dev_addr_oe_n,
   input wire logic dev_data_oe_n,
   input wire logic dev_ctl_oe_n,
   input wire logic dev_access_strobe_n,
   input wire logic dev_wr_strobe_n,
   input wire logic dev_wr_oe_n,
   input wire logic bus_released_ack_n,
   input wire logic dev_ack_oe_n,
   input wire logic dev_global_mem_req_n,
   input wire logic dev_gmr_oe_n,
   input wire logic global_mem_req_n,
   input wire logic fetch_addr_valid_n,
   input wire logic dev_fetch_oe_n,
   input wire logic takeover_req_n,
   input wire logic ready
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////////////
   a_wr_strobe_data: assert property ((!dev_wr_strobe_n && !dev_wr_oe_n)
      |-> !dev_data_oe_n)
      else $error("write strobe low without data driven");
   a_hold_floats_pins: assert property ((!bus_released_ack_n && !dev_ack_oe_n)
      |-> (dev_addr_oe_n && dev_data_oe_n && dev_ctl_oe_n && dev_wr_oe_n))
      else $error("pins driven in hold");
   a_float_outputs: assert property (!i_float_n ##1 !i_float_n
      |-> (dev_ack_oe_n && dev_gmr_oe_n && dev_fetch_oe_n))
      else $error("outputs driven while float low");
   a_global_req_addr: assert property ((!dev_global_mem_req_n && !dev_gmr_oe_n)
      |-> (!dev_addr_oe_n && !dev_addr[15]))
      else $error("global request without address in region");
   a_fetch_addr_out: assert property ((!fetch_addr_valid_n && !dev_fetch_oe_n
      && bus_released_ack_n) |-> !dev_addr_oe_n)
      else $error("fetch indicator without address");
   a_takeover_grant: assert property ($fell(takeover_req_n)
      |-> ##[1:12] !bus_released_ack_n)
      else $error("takeover not granted in time");
   a_dma_grant: assert property ((!bus_released_ack_n && $fell(global_mem_req_n))
      |-> ##[1:4] !fetch_addr_valid_n)
      else $error("ram request not granted");
   a_ready_wait: assert property ((!dev_access_strobe_n && !dev_ctl_oe_n && !ready) [*3]
      |=> !dev_access_strobe_n)
      else $error("access ended without ready");
   c_write: cover property (!dev_wr_strobe_n && !dev_wr_oe_n);
   c_hold: cover property (!bus_released_ack_n && !dev_ack_oe_n);
   c_grant: cover property (!bus_released_ack_n && !fetch_addr_valid_n);
endmodule : ebh_assertions

// ---- dv/ebh_bench.sv ----
`timescale 1ns/1ps
module ebh_bench;
   import ebh_pkg::*;
   `define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
   logic clk = 0, rst = 1, flt_n = 1, rv = 0, rw = 0, rf = 0, rdy = 1, dv = 0, dw = 0;
   logic [1:0] sp = 0;
   logic [15:0] ra = 0, rd = 0, da = 0, dd = 0;
   wire req_rdy, rsp_v, in_hold, ram_we, dma_done, granted;
   wire [15:0] rsp_d, ram_a, ram_d, cap;
   int fail_count = 0, n_checks = 0, cyc = 0;
   ebh_bus_if ebh_bus_if_i ();
   ebh_device ebh_device_i (.i_ref_clk(clk), .i_reset(rst), .bus(ebh_bus_if_i.device),
      .i_float_n(flt_n), .i_req_valid(rv), .o_req_ready(req_rdy), .i_req_write(rw),
      .i_req_fetch(rf), .i_req_space(sp), .i_req_addr(ra), .i_req_wdata(rd),
      .o_rsp_valid(rsp_v), .o_rsp_rdata(rsp_d), .o_in_hold(in_hold), .o_ram_we(ram_we),
      .o_ram_addr(ram_a), .o_ram_wdata(ram_d), .i_ram_rdata(16'h0000));
   ebh_master ebh_master_i (.i_ref_clk(clk), .i_reset(rst), .bus(ebh_bus_if_i.master),
      .i_ready(rdy), .i_dma_valid(dv), .i_dma_write(dw), .i_dma_addr(da),
      .i_dma_wdata(dd), .o_dma_done(dma_done), .o_granted(granted), .o_wr_capture(cap));
   ebh_assertions ebh_assertions_i (.i_ref_clk(clk), .i_reset(rst), .i_float_n(flt_n),
      .dev_addr(ebh_bus_if_i.dev_addr), .dev_addr_oe_n(ebh_bus_if_i.dev_addr_oe_n),
      .dev_data_oe_n(ebh_bus_if_i.dev_data_oe_n), .dev_ctl_oe_n(ebh_bus_if_i.dev_ctl_oe_n),
      .dev_access_strobe_n(ebh_bus_if_i.dev_access_strobe_n),
      .dev_wr_strobe_n(ebh_bus_if_i.dev_wr_strobe_n), .dev_wr_oe_n(ebh_bus_if_i.dev_wr_oe_n),
      .bus_released_ack_n(ebh_bus_if_i.bus_released_ack_n),
      .dev_ack_oe_n(ebh_bus_if_i.dev_ack_oe_n), .dev_gmr_oe_n(ebh_bus_if_i.dev_gmr_oe_n),
      .dev_global_mem_req_n(ebh_bus_if_i.dev_global_mem_req_n),
      .global_mem_req_n(ebh_bus_if_i.global_mem_req_n),
      .fetch_addr_valid_n(ebh_bus_if_i.fetch_addr_valid_n),
      .dev_fetch_oe_n(ebh_bus_if_i.dev_fetch_oe_n),
      .takeover_req_n(ebh_bus_if_i.takeover_req_n), .ready(ebh_bus_if_i.ready));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #50 clk = ~clk;
   end
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // ready held low for lo cycles after the take to stretch the access
   task automatic acc(input logic w, f, input logic [1:0] s, input logic [15:0] a, d,
      input int lo);
      int k;
      logic gs, fs;
      gs = 0;
      fs = 0;
      @(posedge clk);
      {rv, rw, rf, sp, ra, rd, rdy} <= {1'b1, w, f, s, a, d, lo == 0};
      @(negedge clk);
      for (k = 0; k < 50 && req_rdy !== 1'b1; k++) @(negedge clk);
      @(posedge clk) rv <= 0;
      for (k = 0; k < 80 && rsp_v !== 1'b1; k++)
      begin
         @(posedge clk);
         if (k >= lo) rdy <= 1'b1;
         @(negedge clk);
         gs |= (ebh_bus_if_i.global_mem_req_n === 1'b0);
         fs |= (ebh_bus_if_i.fetch_n === 1'b0);
      end
      `CHK(rsp_v, 1'b1)
      `CHK(k >= lo, 1'b1)
      if (w)
      begin
         // capture lands three cycles after the strobe rises, behind the master's synchroniser
         repeat (3) @(negedge clk);
         `CHK(cap, d)
      end
      else
         `CHK(rsp_d, 16'hffff)
      `CHK(gs, s == SPACE_GLOBAL)
      `CHK(fs, f)
   endtask : acc
   task automatic dma(input logic w, input logic [15:0] a, d);
      int k;
      logic ws, hs, fs;
      {ws, hs, fs} = 3'h0;
      @(posedge clk) {dv, dw, da, dd} <= {1'b1, w, a, d};
      @(posedge clk) dv <= 0;
      for (k = 0; k < 200 && dma_done !== 1'b1; k++)
      begin
         @(negedge clk);
         hs |= (ebh_bus_if_i.ack_n === 1'b0 && in_hold === 1'b1);
         fs |= (ebh_bus_if_i.fetch_n === 1'b0 && granted === 1'b1);
         if (ram_we === 1'b1)
         begin
            ws = 1;
            `CHK(ram_a, a)
            `CHK(ram_d, d)
         end
      end
      `CHK(dma_done, 1'b1)
      `CHK({hs, fs}, 2'h3)
      `CHK(ws, w)
      // the device's synced view of the dropped request lags: let the device leave hold first
      for (k = 0; k < 20 && ebh_bus_if_i.ack_n !== 1'b1; k++) @(negedge clk);
      `CHK(in_hold, 1'b0)
      repeat (3) @(negedge clk);
   endtask : dma
   task automatic float_chk();
      @(posedge clk) flt_n <= 0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK(ebh_bus_if_i.dev_ack_oe_n, 1'b1)
      `CHK(ebh_bus_if_i.dev_fetch_oe_n, 1'b1)
      `CHK(ebh_bus_if_i.dev_wr_oe_n, 1'b1)
      `CHK(ebh_bus_if_i.dev_gmr_oe_n, 1'b1)
      @(posedge clk) flt_n <= 1;
   endtask : float_chk
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fail_count++;
         complete_run();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      acc(1, 0, SPACE_PROG, 16'h0012, 16'ha5a5, 0);
      acc(1, 0, SPACE_DATA, 16'h0034, 16'h5a5a, 6);
      acc(1, 0, SPACE_IO, 16'h0007, 16'h1234, 0);
      acc(1, 0, SPACE_GLOBAL, 16'h8003, 16'h0ff0, 4);
      acc(0, 1, SPACE_PROG, 16'h0040, 16'h0000, 0);
      dma(1, 16'h0105, 16'hbeef);
      dma(0, 16'h0106, 16'h0000);
      float_chk();
      complete_run();
   end
endmodule : ebh_bench
